// *** hw/pgsr_top.sv ***
`include "pgsr_map.svh"
`default_nettype none

// Overview of operation
// R1: Phase summary bit n marks slot n fault
// R2: Broadcast reads slots, else active status bit
// R3: Assert delay from bits 15:12 in ticks
// R4: Release delay from bits 11:8 in ticks
// R5: Mask bit one blocks that event
// R6: Good low while disabled or ramping or faulted
// R7: Turn-off ramp and shutdown skip assert delay
// R8: Continue-response faults never pull good low
// R9: Assert and release delays timed independently
// R10: Good control and stack writable only disabled
// R11: Bits 7:6 select clock pin mode
// R12: Bit 5 selects lock edge
// R13: Host writes bits 4:0 as 10000b
// R14: Invalid lock control write rejected, host alerted
// R15: Auto mode decides once at enable
// R16: High or fast pin follows, quiet drives
// R17: Slave follows; flags missing or lost clock
// R18: Host sets stack master to drive
// R19: Follow floor frequency kept until disable
// R20: Drive change during lock loss runs slow
// R21: Stack nibble zero to three, start zero
// R22: Delay counters count switching ticks, restart
module pgsr_top
(
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic [7:0]  cmdCode,
	input  wire logic        cmdWrite,
	input  wire logic        cmdRead,
	input  wire logic [15:0] cmdWdata,
	input  wire logic        alertClear,
	input  wire logic [7:0]  phaseSel,
	input  wire logic [3:0]  slotFault,
	input  wire logic [3:0]  slotUsed,
	input  wire logic        activeStatus,
	input  wire logic        convEnable,
	input  wire logic        inTurnOnDelay,
	input  wire logic        inTurnOnRamp,
	input  wire logic        inTurnOffRamp,
	input  wire logic        inFaultShutdown,
	input  wire logic [7:0]  eventRaw,
	input  wire logic [7:0]  eventContinue,
	input  wire logic        pwmTick,
	input  wire logic        syncPin,
	input  wire logic [11:0] swPeriod,
	input  wire logic        isStackSlave,
	input  wire logic        atFollowFloor,
	output logic [15:0]      rdData_r,
	output logic             rdValid_r,
	output logic             dataErr_r,
	output logic             alertN_r,
	output logic             goodOut_r,
	output logic             syncDrive_r,
	output logic             syncFollow_r,
	output logic             lockEdge_r,
	output logic             lockLoss_r,
	output logic             oscSlow_r,
	output logic [3:0]       stackLast_r
);
	import pgsr_pkg::*;

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [3:0]  phaseSticky_r;  // Per-slot fault marks
	logic [15:0] goodCtrl_r;     // Delays and masks
	logic [7:0]  clkCtrl_r;      // Mode, edge, fill pattern
	logic        convEnPrev_r;   // Enable edge finder
	logic        autoFollow_r;   // Auto decision, kept per enable
	logic        followPrev_r;   // Mode one cycle ago

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	logic wrPhase;
	logic wrGood;
	logic wrClock;
	logic wrStack;
	logic clockValid;
	logic stackValid;
	logic badWrite;

	assign wrPhase = cmdWrite && (cmdCode == `PGSR_CMD_PHASE);
	assign wrGood  = cmdWrite && (cmdCode == `PGSR_CMD_GOOD);
	assign wrClock = cmdWrite && (cmdCode == `PGSR_CMD_CLOCK);
	assign wrStack = cmdWrite && (cmdCode == `PGSR_CMD_STACK);

	// Only the fixed fill pattern is legal in the low bits
	assign clockValid = (cmdWdata[`PGSR_FILL_HI:0] == `PGSR_CLOCK_FILL);
	// Upper bits must be zero and the nibble at most four-phase
	assign stackValid = (cmdWdata[15:4] == 12'h000) &&
	                    (cmdWdata[3:0] <= `PGSR_STACK_MAX);        // R21
	assign badWrite   = (wrClock && !clockValid) ||                // R14
	                    (wrStack && !stackValid);

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	logic [15:0] phaseRead;
	logic [15:0] rdMux;

	// Broadcast shows slots; otherwise just the active one
	assign phaseRead = (phaseSel == `PGSR_BROADCAST)               // R2
	                 ? {12'h000, phaseSticky_r & slotUsed}         // R1
	                 : {15'h0000, activeStatus};

	always_comb
	begin
		rdMux = 16'h0000;    // Unmapped codes read zero
		unique case (cmdCode)
			`PGSR_CMD_PHASE: rdMux = phaseRead;
			`PGSR_CMD_GOOD:  rdMux = goodCtrl_r;
			`PGSR_CMD_CLOCK: rdMux = {8'h00, clkCtrl_r};
			`PGSR_CMD_STACK: rdMux = {12'h000, stackLast_r}; // R21
			default:         rdMux = 16'h0000;
		endcase
	end

	// Read answer one cycle after the request
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rdData_r  <= 16'h0000;
			rdValid_r <= 1'b0;
		end
		else
		begin
			rdValid_r <= cmdRead;
			if (cmdRead)
				rdData_r <= rdMux;
		end
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	// Fault marks: write one to clear, a new fault wins
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			phaseSticky_r <= 4'h0;
		else
			phaseSticky_r <= (phaseSticky_r &
			                  ~(wrPhase ? cmdWdata[3:0] : 4'h0)) |
			                 (slotFault & slotUsed);               // R1
	end

	// Configuration writes; good control and stack locked while converting
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			goodCtrl_r  <= `PGSR_GOOD_RST;
			clkCtrl_r   <= `PGSR_CLOCK_RST;
			stackLast_r <= `PGSR_STACK_RST;
		end
		else
		begin
			if (wrGood && !convEnable)
				goodCtrl_r <= cmdWdata;                          // R10
			if (wrClock && clockValid)
				clkCtrl_r <= cmdWdata[7:0];                      // R14
			if (wrStack && stackValid && !convEnable)
				stackLast_r <= cmdWdata[3:0];                    // R10
		end
	end

	// Unsupported data pulse and sticky alert; new error wins
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			dataErr_r <= 1'b0;
			alertN_r  <= 1'b1;
		end
		else
		begin
			dataErr_r <= badWrite;                               // R14
			alertN_r  <= ~(badWrite | (~alertN_r & ~alertClear));
		end
	end

	// ------------------------------------------------------------
	// Output good logic
	// ------------------------------------------------------------
	logic [7:0] eventLive;
	logic       badNow;
	logic       forceLow;
	logic       assertRun;
	logic       releaseRun;
	logic       assertDone;
	logic       releaseDone;

	// Masked and continue-response events cannot pull low
	assign eventLive = eventRaw & ~goodCtrl_r[`PGSR_MASK_HI:0]     // R5
	                            & ~eventContinue;                  // R8
	assign badNow    = |eventLive;
	assign forceLow  = !convEnable || inTurnOnDelay ||             // R6
	                   inTurnOnRamp || inTurnOffRamp ||
	                   inFaultShutdown;
	// Each timer only sees its own condition
	assign assertRun  = goodOut_r && badNow;                       // R9
	assign releaseRun = !goodOut_r && !badNow && !forceLow;        // R9

	pgsr_delay_timer assertTimer
	(
		.sys_clk   (sys_clk),
		.resetn    (resetn),
		.run       (assertRun),
		.tick      (pwmTick),
		.delayCode (goodCtrl_r[`PGSR_ASSERT_HI:`PGSR_ASSERT_LO]),  // R3
		.done      (assertDone)
	);

	pgsr_delay_timer releaseTimer
	(
		.sys_clk   (sys_clk),
		.resetn    (resetn),
		.run       (releaseRun),
		.tick      (pwmTick),
		.delayCode (goodCtrl_r[`PGSR_RELEASE_HI:`PGSR_RELEASE_LO]),// R4
		.done      (releaseDone)
	);

	// Forced states bypass the assert delay entirely
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			goodOut_r <= 1'b0;
		else if (forceLow)
			goodOut_r <= 1'b0;                                   // R7
		else if (goodOut_r && assertDone)
			goodOut_r <= 1'b0;                                   // R3
		else if (!goodOut_r && releaseDone)
			goodOut_r <= 1'b1;                                   // R4
	end

	// ------------------------------------------------------------
	// Clock pin mode
	// ------------------------------------------------------------
	pgsr_sync_if    syncBus ();
	pgsr_clk_mode_e cfgMode;
	logic           enRise;
	logic           follow;
	logic           drive;
	logic           cfgFollow;  // Mode asks to follow the pin
	logic           cfgDrive;   // Mode asks to drive the pin

	assign cfgMode        = pgsr_mode_of(
	                        clkCtrl_r[`PGSR_MODE_HI:`PGSR_MODE_LO]);  // R11
	assign syncBus.edgeSel = clkCtrl_r[`PGSR_EDGE_BIT];             // R12
	assign enRise          = convEnable && !convEnPrev_r;

	pgsr_pin_detect pinDetect
	(
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.syncPin  (syncPin),
		.swPeriod (swPeriod),
		.sy       (syncBus)
	);

	// Roles the mode asks for, before the stack role overrides them
	assign cfgFollow = (cfgMode == CLK_FOLLOW) ||
	                   ((cfgMode == CLK_AUTO) && autoFollow_r);
	assign cfgDrive  = (cfgMode == CLK_DRIVE) ||
	                   ((cfgMode == CLK_AUTO) && !autoFollow_r);
	// A stack slave always follows, whatever the mode
	assign follow = isStackSlave || cfgFollow;                     // R17
	assign drive  = !isStackSlave && cfgDrive;                     // R11

	// Auto choice made once per enable from the pin state
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			convEnPrev_r <= 1'b0;
			autoFollow_r <= 1'b0;
			followPrev_r <= 1'b0;
		end
		else
		begin
			convEnPrev_r <= convEnable;
			followPrev_r <= cfgFollow;
			if (enRise)                                           // R15
				autoFollow_r <= syncBus.pinHigh ||
				                syncBus.fastToggle;               // R16
		end
	end

	// Pin roles and lock edge pulse
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			syncDrive_r  <= 1'b0;
			syncFollow_r <= 1'b0;
			lockEdge_r   <= 1'b0;
		end
		else
		begin
			syncDrive_r  <= drive;
			syncFollow_r <= follow;
			lockEdge_r   <= follow && syncBus.edgeHit;            // R12
		end
	end

	// Lock loss and reduced oscillator, both end on disable
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			lockLoss_r <= 1'b0;
			oscSlow_r  <= 1'b0;
		end
		else if (!convEnable)
		begin
			lockLoss_r <= 1'b0;
			oscSlow_r  <= 1'b0;
		end
		else
		begin
			if (isStackSlave && !syncBus.clkPresent)
				lockLoss_r <= 1'b1;                              // R17
			// Mode change, not pin role: a slave still follows
			if (followPrev_r && cfgDrive &&
			    (atFollowFloor || lockLoss_r))
				oscSlow_r <= 1'b1;                               // R19 R20
		end
	end
endmodule

`default_nettype wire

// *** inc/pgsr_map.svh ***
`ifndef PGSR_MAP_SVH
`define PGSR_MAP_SVH

// ----------------------------------------------------------------
// Command codes of the four registers
// ----------------------------------------------------------------
`define PGSR_CMD_PHASE      8'hDC
`define PGSR_CMD_GOOD       8'hE3
`define PGSR_CMD_CLOCK      8'hE4
`define PGSR_CMD_STACK      8'hEC

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PGSR_ASSERT_HI      15
`define PGSR_ASSERT_LO      12
`define PGSR_RELEASE_HI     11
`define PGSR_RELEASE_LO     8
`define PGSR_MASK_HI        7
`define PGSR_MODE_HI        7
`define PGSR_MODE_LO        6
`define PGSR_EDGE_BIT       5
`define PGSR_FILL_HI        4

// ----------------------------------------------------------------
// Reset and fixed values
// ----------------------------------------------------------------
`define PGSR_GOOD_RST       16'h0000
`define PGSR_CLOCK_RST      8'h10
`define PGSR_CLOCK_FILL     5'h10
`define PGSR_STACK_RST      4'h0
`define PGSR_STACK_MAX      4'h3
`define PGSR_BROADCAST      8'hFF

// ----------------------------------------------------------------
// Timing ratios for the clock pin detector
// ----------------------------------------------------------------
`define PGSR_FAST_NUM       14'h0004
`define PGSR_FAST_DEN       14'h0003
`define PGSR_LOSS_MULT      14'h0002
`define PGSR_GAP_MAX        14'h3FFF

`endif

// *** inc/pgsr_pkg.sv ***
`default_nettype none

package pgsr_pkg;

	// Clock pin mode as held in the lock control register
	typedef enum logic [1:0] {
		CLK_OFF,
		CLK_DRIVE,
		CLK_FOLLOW,
		CLK_AUTO
	} pgsr_clk_mode_e;

	// Delay length in switching ticks
	typedef logic [16:0] pgsr_tick_t;

	// Field to mode
	function automatic pgsr_clk_mode_e pgsr_mode_of(input logic [1:0] f);
		pgsr_clk_mode_e m;
		m = CLK_OFF;
		unique case (f)
			2'h0: m = CLK_OFF;
			2'h1: m = CLK_DRIVE;
			2'h2: m = CLK_FOLLOW;
			2'h3: m = CLK_AUTO;
		endcase
		return m;
	endfunction

	// Code 0 is one tick, code N is 2^N+1 ticks
	function automatic pgsr_tick_t pgsr_delay_ticks(input logic [3:0] n);
		pgsr_tick_t t;
		t = 17'h00001;
		if (n != 4'h0)
			t = (17'h00001 << n) + 17'h00001;
		return t;
	endfunction

endpackage

`default_nettype wire

// *** inc/pgsr_sync_if.sv ***
`default_nettype none

// Clock pin detector results and the chosen lock edge
interface pgsr_sync_if;
	logic edgeSel;     // 1 rising, 0 falling
	logic edgeHit;     // Selected edge seen, one cycle
	logic pinHigh;     // Filtered pin level
	logic fastToggle;  // Edges faster than the threshold
	logic clkPresent;  // An edge arrived recently

	modport det
	(
		input  edgeSel,
		output edgeHit,
		output pinHigh,
		output fastToggle,
		output clkPresent
	);

	modport ctl
	(
		output edgeSel,
		input  edgeHit,
		input  pinHigh,
		input  fastToggle,
		input  clkPresent
	);
endinterface

`default_nettype wire

// *** hw/pgsr_delay_timer.sv ***
`include "pgsr_map.svh"
`default_nettype none

// Counts switching ticks while its condition holds
module pgsr_delay_timer
(
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	input  wire logic       run,
	input  wire logic       tick,
	input  wire logic [3:0] delayCode,
	output logic            done
);
	import pgsr_pkg::*;

	pgsr_tick_t cnt_r;   // Ticks seen so far
	pgsr_tick_t target;  // Ticks needed

	assign target = pgsr_delay_ticks(delayCode);
	assign done   = run && (cnt_r >= target);

	// Restart whenever the condition drops before expiry
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			cnt_r <= '0;
		else if (!run)
			cnt_r <= '0;                   // R22
		else if (tick && (cnt_r < target))
			cnt_r <= cnt_r + 17'h00001;    // R22
	end
endmodule

`default_nettype wire

// *** hw/pgsr_pin_detect.sv ***
`include "pgsr_map.svh"
`default_nettype none

// Samples the clock pin, finds edges and measures their spacing
module pgsr_pin_detect
(
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic        syncPin,
	input  wire logic [11:0] swPeriod,
	pgsr_sync_if.det         sy
);
	import pgsr_pkg::*;

	logic [2:0]  pinSync_r;  // Three-stage synchroniser
	logic        pinLvl_r;   // Accepted level
	logic        lvlPrev_r;  // Level one cycle ago
	logic        edgeHit_r;  // Selected edge pulse
	logic [13:0] gap_r;      // Cycles since last selected edge
	logic [13:0] lastGap_r;  // Spacing of the last two edges
	logic        agree;
	logic        hit;
	logic [13:0] perWide;
	logic [13:0] fastLimit;
	logic [13:0] lossLimit;

	// ------------------------------------------------------------
	// Filtering and edge selection
	// ------------------------------------------------------------
	// Stage 0 feeds stage 1 only; a level counts once 1 and 2 agree
	assign agree = (pinSync_r[1] == pinSync_r[2]);
	assign hit   = sy.edgeSel ? (pinLvl_r & ~lvlPrev_r)   // R12
	                          : (~pinLvl_r & lvlPrev_r);

	// Period threshold: faster than 75% of nominal frequency
	assign perWide   = {2'h0, swPeriod};
	assign fastLimit = 14'((perWide * `PGSR_FAST_NUM) / `PGSR_FAST_DEN);
	// Loss window long enough for the 70% floor
	assign lossLimit = 14'(perWide * `PGSR_LOSS_MULT);

	// Synchroniser and level filter
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pinSync_r <= 3'h0;
			pinLvl_r  <= 1'b0;
			lvlPrev_r <= 1'b0;
			edgeHit_r <= 1'b0;
		end
		else
		begin
			pinSync_r <= {pinSync_r[1:0], syncPin};
			if (agree)
				pinLvl_r <= pinSync_r[2];
			lvlPrev_r <= pinLvl_r;
			edgeHit_r <= hit;
		end
	end

	// ------------------------------------------------------------
	// Edge spacing
	// ------------------------------------------------------------
	// Saturating gap counter, sampled at each selected edge
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			gap_r     <= `PGSR_GAP_MAX;
			lastGap_r <= `PGSR_GAP_MAX;
		end
		else if (hit)
		begin
			lastGap_r <= gap_r;
			gap_r     <= 14'h0001;
		end
		else if (gap_r != `PGSR_GAP_MAX)
			gap_r <= gap_r + 14'h0001;
	end

	assign sy.edgeHit    = edgeHit_r;
	assign sy.pinHigh    = pinLvl_r;
	assign sy.clkPresent = (gap_r < lossLimit);
	assign sy.fastToggle = sy.clkPresent && (lastGap_r < fastLimit);
endmodule

`default_nettype wire

// *** dv/pgsr_host.sv ***
`default_nettype none

// ------
// Host model of the command port
// ------
module pgsr_host
(
	input  wire logic        sys_clk,
	input  wire logic [15:0] rdData_r,
	output logic [7:0]       cmdCode,
	output logic             cmdWrite,
	output logic             cmdRead,
	output logic [15:0]      cmdWdata
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle port until the first command
	initial
	begin
		cmdCode = 8'h00;
		cmdWrite = 1'b0;
		cmdRead = 1'b0;
		cmdWdata = 16'h0000;
	end

	// One write, held for exactly one taking edge
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(posedge sys_clk);
		#1;
		cmdCode = c;
		cmdWdata = d;
		cmdWrite = 1'b1;
		@(posedge sys_clk);
		#1;
		cmdWrite = 1'b0;
		cmdWdata = ~d;  // Released data must not linger
	endtask

	// One read; data is settled just after the taking edge
	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		@(posedge sys_clk);
		#1;
		cmdCode = c;
		cmdRead = 1'b1;
		@(posedge sys_clk);
		#1;
		cmdRead = 1'b0;
		d = rdData_r;
	endtask

	// Lock control always carries the fixed fill
	task automatic clkWr(input logic [1:0] m, input logic e);
		wr(8'hE4, {8'h00, m, e, 5'h10});
	endtask
endmodule

`default_nettype wire

// *** dv/pgsr_top_sva.sv ***
`default_nettype none

// ------
// Port checks of the register block
// ------
module pgsr_top_sva
(
	input wire logic        sys_clk,
	input wire logic        resetn,
	input wire logic [7:0]  cmdCode,
	input wire logic        cmdWrite,
	input wire logic        cmdRead,
	input wire logic [15:0] cmdWdata,
	input wire logic [7:0]  phaseSel,
	input wire logic        activeStatus,
	input wire logic        convEnable,
	input wire logic        inTurnOnDelay,
	input wire logic        inTurnOnRamp,
	input wire logic        inTurnOffRamp,
	input wire logic        inFaultShutdown,
	input wire logic [7:0]  eventRaw,
	input wire logic [7:0]  eventContinue,
	input wire logic        pwmTick,
	input wire logic [15:0] rdData_r,
	input wire logic        dataErr_r,
	input wire logic        alertN_r,
	input wire logic        goodOut_r,
	input wire logic        syncFollow_r,
	input wire logic        lockEdge_r,
	input wire logic        oscSlow_r,
	input wire logic [3:0]  stackLast_r
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	// Any phase that forbids a good output
	wire       forceLow = !convEnable || inTurnOnDelay || inTurnOnRamp
		|| inTurnOffRamp || inFaultShutdown;
	// Events not set to continue; mask not applied
	wire [7:0] liveRaw = eventRaw & ~eventContinue;

	sequence s_rdPhase;
		cmdRead && cmdCode == 8'hDC;
	endsequence
	sequence s_badClk;
		cmdWrite && cmdCode == 8'hE4 && cmdWdata[4:0] != 5'h10;
	endsequence

	property p_phaseHi;
		s_rdPhase |=> rdData_r[15:4] == 12'h000;
	endproperty
	a_phaseHi: assert property (p_phaseHi) else $error("DC high bits");
	property p_phaseSel;
		s_rdPhase ##0 phaseSel != 8'hFF
			|=> rdData_r == {15'h0000, $past(activeStatus)};
	endproperty
	a_phaseSel: assert property (p_phaseSel) else $error("DC slot");
	property p_forceLow;
		forceLow |=> !goodOut_r;
	endproperty
	a_forceLow: assert property (p_forceLow) else $error("good kept");
	property p_fallCause;
		$fell(goodOut_r) |-> $past(forceLow || liveRaw != 8'h00);
	endproperty
	a_fallCause: assert property (p_fallCause) else $error("good fell");
	property p_riseTick;
		$rose(goodOut_r) |-> $past(pwmTick, 2);
	endproperty
	a_riseTick: assert property (p_riseTick) else $error("rise tick");
	property p_badClk;
		s_badClk |=> dataErr_r && !alertN_r;
	endproperty
	a_badClk: assert property (p_badClk) else $error("bad lock");
	property p_stackHold;
		cmdWrite && cmdCode == 8'hEC && convEnable |=> $stable(stackLast_r);
	endproperty
	a_stackHold: assert property (p_stackHold) else $error("stack");
	property p_lockEdge;
		lockEdge_r |-> syncFollow_r;
	endproperty
	a_lockEdge: assert property (p_lockEdge) else $error("lock edge");
	property p_oscSlow;
		$rose(oscSlow_r) |-> $past(convEnable);
	endproperty
	a_oscSlow: assert property (p_oscSlow) else $error("slow osc");
endmodule

`default_nettype wire

// *** dv/pgsr_top_tb.sv ***
`default_nettype none

bind pgsr_top pgsr_top_sva u_pgsr_top_sva (.*);

// ------
// Self-checking bench
// ------
module pgsr_top_tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic        sys_clk = 1'b0;
	logic        resetn, alertClear, activeStatus, convEnable, isStackSlave;
	logic        inTurnOnDelay, inTurnOnRamp, inTurnOffRamp, inFaultShutdown;
	logic        pwmTick, syncPin, atFollowFloor, linkRun, e;
	logic        cmdWrite, cmdRead, rdValid_r, dataErr_r, alertN_r;
	logic        goodOut_r, syncDrive_r, syncFollow_r, lockEdge_r;
	logic        lockLoss_r, oscSlow_r;
	logic [1:0]  tc;
	logic [3:0]  slotFault, slotUsed, stackLast_r, a, r;
	logic [7:0]  cmdCode, phaseSel, eventRaw, eventContinue;
	logic [11:0] swPeriod;
	logic [15:0] cmdWdata, rdData_r, rd;
	logic [7:0]  codes [5] = '{8'hDC, 8'hE3, 8'hE4, 8'hEC, 8'h00};
	logic [15:0] rstv [5] = '{16'h0000, 16'h0000, 16'h0010, 16'h0000, 16'h0000};
	int          error_cnt = 0;
	int          checks_done = 0;
	int          i, b, t, n;

	pgsr_top u_pgsr_top (.*);
	pgsr_host u_pgsr_host (.*);

	// 25 MHz system clock
	always #20 sys_clk = ~sys_clk;
	// Switching tick every fourth cycle, spaced for counting
	always @(posedge sys_clk)
	begin
		tc <= tc + 2'h1;
		pwmTick <= #1 (tc == 2'h3);
	end
	// Link clock, 320 ns, stands low when stopped
	always #160 syncPin = linkRun ? ~syncPin : 1'b0;

	task automatic chk16(input logic [15:0] g, input logic [15:0] x);
		checks_done++;
		if (g !== x)
		begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task automatic chk1(input logic g, input logic x);
		chk16({15'h0000, g}, {15'h0000, x});
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	// Ticks of a delay code: 1, or 2^N+1
	function automatic int ticks(input logic [3:0] c);
		return (c == 4'h0) ? 1 : (1 << c) + 1;
	endfunction
	// Wait for a good level, counting ticks on the way
	task automatic waitGood(input logic lvl, output int s);
		int k;
		s = 0;
		for (k = 0; k < 400 && goodOut_r !== lvl; k++)
		begin
			@(posedge sys_clk);
			s += int'(pwmTick);
			#1;
		end
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Hang guard
	initial
	begin
		#1000000;
		error_cnt++;
		end_sim;
	end

	initial
	begin
		n = $urandom(32'h5F5C);
		{resetn, alertClear, activeStatus, convEnable, isStackSlave} = 5'h00;
		{inTurnOnDelay, inTurnOnRamp, inTurnOffRamp, inFaultShutdown} = 4'h0;
		{linkRun, atFollowFloor, syncPin, pwmTick} = 4'h0;
		{slotFault, slotUsed, phaseSel, eventRaw, eventContinue} = 32'h0;
		{tc, swPeriod} = 14'h000A;
		repeat (10) @(posedge sys_clk);
		#1;
		resetn = 1'b1;
		// Reset values, unmapped code last
		for (i = 0; i < 5; i++)
		begin
			u_pgsr_host.rd(codes[i], rd);
			chk16(rd, rstv[i]);
			chk1(rdValid_r, 1'b1);
		end
		// Every lock mode, each with a random edge
		for (i = 0; i < 4; i++)
		begin
			e = 1'($urandom_range(1));
			u_pgsr_host.clkWr(2'(i), e);
			u_pgsr_host.rd(8'hE4, rd);
			chk16(rd, {8'h00, 2'(i), e, 5'h10});
		end
		// Bad fill refused, alert held until cleared
		u_pgsr_host.wr(8'hE4, 16'($urandom_range(15)));
		chk1(dataErr_r, 1'b1);
		chk1(alertN_r, 1'b0);
		u_pgsr_host.rd(8'hE4, rd);
		chk16(rd, {8'h00, 2'h3, e, 5'h10});
		alertClear = 1'b1;
		cyc(1);
		alertClear = 1'b0;
		chk1(alertN_r, 1'b1);
		// Stack layout codes, invalid and locked writes
		for (i = 0; i < 4; i++)
		begin
			u_pgsr_host.wr(8'hEC, 16'(i));
			u_pgsr_host.rd(8'hEC, rd);
			chk16(rd, 16'(i));
		end
		u_pgsr_host.wr(8'hEC, 16'($urandom_range(15, 4)));
		chk1(dataErr_r, 1'b1);
		convEnable = 1'b1;
		u_pgsr_host.wr(8'hEC, 16'h0001);
		chk16(16'(stackLast_r), 16'h0003);
		convEnable = 1'b0;
		// Phase summary: broadcast, clear, single slot
		slotFault = 4'($urandom);
		slotUsed = 4'($urandom);
		phaseSel = 8'hFF;
		u_pgsr_host.rd(8'hDC, rd);
		chk16(rd, {12'h000, slotFault & slotUsed});
		slotFault = 4'h0;
		u_pgsr_host.wr(8'hDC, 16'h000F);
		u_pgsr_host.rd(8'hDC, rd);
		chk16(rd, 16'h0000);
		phaseSel = 8'($urandom_range(3));
		activeStatus = 1'($urandom);
		u_pgsr_host.rd(8'hDC, rd);
		chk16(rd, {15'h0000, activeStatus});
		// Good output delays, masks and forced phases
		for (i = 0; i < 4; i++)
		begin
			b = $urandom_range(7);
			a = 4'($urandom_range(3));
			r = 4'($urandom_range(3));
			convEnable = 1'b0;
			u_pgsr_host.wr(8'hE3, {a, r, ~(8'h01 << b)});
			convEnable = 1'b1;
			waitGood(1'b1, t);
			chk16(16'(t), 16'(ticks(r)));
			// One-cycle event is shorter than any assert delay
			eventRaw = 8'h01 << b;
			cyc(1);
			eventRaw = 8'h00;
			cyc(8);
			chk1(goodOut_r, 1'b1);
			eventRaw = ~(8'h01 << b);
			cyc(60);
			chk1(goodOut_r, 1'b1);
			eventRaw = 8'hFF;
			eventContinue = 8'h01 << b;
			cyc(60);
			chk1(goodOut_r, 1'b1);
			eventContinue = 8'h00;
			waitGood(1'b0, t);
			chk16(16'(t), 16'(ticks(a)));
			eventRaw = 8'h00;
			waitGood(1'b1, t);
			chk16(16'(t), 16'(ticks(r)));
			u_pgsr_host.wr(8'hE3, 16'h0000);
			u_pgsr_host.rd(8'hE3, rd);
			chk16(rd, {a, r, ~(8'h01 << b)});
			{inTurnOnDelay, inTurnOnRamp, inTurnOffRamp, inFaultShutdown} =
				4'h1 << i;
			cyc(1);
			chk1(goodOut_r, 1'b0);
			{inTurnOnDelay, inTurnOnRamp, inTurnOffRamp, inFaultShutdown} = 4'h0;
		end
		// Lone master drives the clock
		convEnable = 1'b0;
		u_pgsr_host.clkWr(2'h1, 1'b0);
		convEnable = 1'b1;
		cyc(4);
		chk1(syncDrive_r, 1'b1);
		// Follow: lock pulses counted on the chosen edge
		linkRun = 1'b1;
		for (i = 0; i < 2; i++)
		begin
			convEnable = 1'b0;
			u_pgsr_host.clkWr(2'h2, 1'(i));
			convEnable = 1'b1;
			n = 0;
			repeat (80)
			begin
				cyc(1);
				// Pulse trails the pin by more than half a period
				n += int'(lockEdge_r && syncPin === ~1'(i));
			end
			chk1(n > 8 && n < 12, 1'b1);
		end
		// Auto decides once, at enable
		convEnable = 1'b0;
		linkRun = 1'b0;
		u_pgsr_host.clkWr(2'h3, 1'b0);
		// Let the last seen edge age out of the presence window
		cyc(40);
		convEnable = 1'b1;
		cyc(8);
		chk1(syncDrive_r, 1'b1);
		linkRun = 1'b1;
		cyc(40);
		chk1(syncFollow_r, 1'b0);
		convEnable = 1'b0;
		cyc(40);
		convEnable = 1'b1;
		cyc(8);
		chk1(syncFollow_r, 1'b1);
		// Follow to drive at the floor keeps it slow
		atFollowFloor = 1'b1;
		u_pgsr_host.clkWr(2'h2, 1'b0);
		u_pgsr_host.clkWr(2'h1, 1'b0);
		cyc(2);
		chk1(oscSlow_r, 1'b1);
		convEnable = 1'b0;
		atFollowFloor = 1'b0;
		cyc(2);
		chk1(oscSlow_r, 1'b0);
		// Slave enabled with no clock present
		linkRun = 1'b0;
		isStackSlave = 1'b1;
		u_pgsr_host.clkWr(2'h2, 1'b0);
		convEnable = 1'b1;
		cyc(40);
		chk1(lockLoss_r, 1'b1);
		u_pgsr_host.clkWr(2'h1, 1'b0);
		cyc(2);
		chk1(oscSlow_r, 1'b1);
		convEnable = 1'b0;
		cyc(2);
		chk1(lockLoss_r, 1'b0);
		end_sim;
	end
endmodule

`default_nettype wire
